//--- include/mpcd_consts.svh
// timing counts, status codes and decode constants for the midi playback decoder
`ifndef MPCD_CONSTS_SVH
`define MPCD_CONSTS_SVH

`define MPCD_CLK_NS       50                               // ref_clk period in ns
`define MPCD_BIT_NS       32000                            // one bit at 31250 bit/s, in ns
`define MPCD_BIT_CYC      (`MPCD_BIT_NS / `MPCD_CLK_NS)    // clocks per bit
`define MPCD_HALF_CYC     (`MPCD_BIT_CYC / 2)              // clocks to mid start bit
`define MPCD_FRAME_BITS   4'h9                             // index of stop bit in a frame

`define MPCD_ST_PAGE      4'hC                             // program change status nibble
`define MPCD_ST_NOTE_ON   4'h9                             // note-on status nibble
`define MPCD_ST_NOTE_OFF  4'h8                             // note-off status nibble
`define MPCD_ST_CHASE     4'hA                             // aftertouch status nibble
`define MPCD_ST_SYSTEM    4'hF                             // system status nibble
`define MPCD_QF_STATUS    8'hF1                            // timecode quarter frame status

`define MPCD_FADER_MAX    7'h13                            // last playback index (19)
`define MPCD_CHASE_MAX    7'h04                            // last chase control code
`define MPCD_QF_LAST      3'h7                             // last quarter frame piece

`define MPCD_PG_A_FIRST   7'h7D                            // bank a page 1 value
`define MPCD_PG_A_BASE    7'h7C                            // bank a: page = value - base
`define MPCD_PG1_FIRST    7'h02                            // page 1, bank b
`define MPCD_PG1_LAST     7'h0A                            // page 1, bank j
`define MPCD_PG1_BASE     7'h01                            // page 1: bank = value - base
`define MPCD_PG2_FIRST    7'h0C                            // page 2, bank b
`define MPCD_PG2_LAST     7'h14                            // page 2, bank j
`define MPCD_PG2_BASE     7'h0B                            // page 2: bank = value - base
`define MPCD_PG3_FIRST    7'h15                            // page 3, bank b
`define MPCD_PG3_LAST     7'h1D                            // page 3, bank j
`define MPCD_PG3_BASE     7'h14                            // page 3: bank = value - base

`endif

//--- include/mpcd_pkg.sv
// types shared by the midi playback decoder
package mpcd_pkg;

  // operating mode from the desk configuration
  typedef enum logic [1:0] {
    MPCD_MODE_OFF    = 2'h0,
    MPCD_MODE_SLAVE  = 2'h1,
    MPCD_MODE_MASTER = 2'h2
  } mpcd_mode_type;

  // page selection: bank 0..9 is a..j, page 1..3
  typedef struct packed {
    logic [3:0] bank;
    logic [1:0] page;
  } mpcd_page_type;

  // playback fader setting
  typedef struct packed {
    logic [4:0] index;
    logic [6:0] level;
  } mpcd_fader_type;

  // chase control request
  typedef struct packed {
    logic [4:0] index;
    logic [2:0] code;
  } mpcd_chase_type;

  // assembled timecode
  typedef struct packed {
    logic [1:0] rate;
    logic [4:0] hours;
    logic [5:0] mins;
    logic [5:0] secs;
    logic [4:0] frames;
  } mpcd_time_type;

  // note to send in master mode
  typedef struct packed {
    logic       on;
    logic [6:0] key;
    logic [6:0] vel;
  } mpcd_note_type;

endpackage

//--- hw/mpcd_uart_rx.sv
// serial byte receiver for the midi input pin
`timescale 1ns/1ns
`default_nettype none
`include "mpcd_consts.svh"

module mpcd_uart_rx
  import mpcd_pkg::*;
(
  input  wire logic       ref_clk,
  input  wire logic       resetn,
  input  wire logic       rx_pin,
  output var  logic [7:0] byte_q,
  output var  logic       byte_valid_q
);

  typedef enum logic [1:0] {RX_IDLE, RX_START, RX_DATA, RX_STOP} mpcd_rx_state_type;

  logic              s1_q;                  // first sync stage
  logic              s2_q;                  // second sync stage
  mpcd_rx_state_type st_q, st_d;            // frame state
  logic [9:0]        cnt_q, cnt_d;          // bit timer
  logic [2:0]        bit_q, bit_d;          // data bit index
  logic [7:0]        sh_q, sh_d;            // assembled byte
  logic [7:0]        byte_d;                // next output byte
  logic              byte_valid_d;          // next output strobe

  // frame sequencing, lsb first, 8n1
  always_comb begin
    st_d         = st_q;
    cnt_d        = cnt_q + 10'h001;
    bit_d        = bit_q;
    sh_d         = sh_q;
    byte_d       = byte_q;
    byte_valid_d = 1'b0;
    unique case (st_q)
      RX_IDLE: begin
        cnt_d = 10'h000;
        if (!s2_q) begin                    // start edge seen
          st_d = RX_START;
        end
      end
      RX_START: begin
        if (cnt_q == 10'(`MPCD_HALF_CYC - 1)) begin
          cnt_d = 10'h000;
          st_d  = s2_q ? RX_IDLE : RX_DATA; // glitch returns to idle
          bit_d = 3'h0;
        end
      end
      RX_DATA: begin
        if (cnt_q == 10'(`MPCD_BIT_CYC - 1)) begin
          cnt_d = 10'h000;
          sh_d  = {s2_q, sh_q[7:1]};
          bit_d = bit_q + 3'h1;
          if (bit_q == 3'h7) begin
            st_d = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (cnt_q == 10'(`MPCD_BIT_CYC - 1)) begin
          st_d = RX_IDLE;
          if (s2_q) begin                   // good stop bit only
            byte_d       = sh_q;
            byte_valid_d = 1'b1;
          end
        end
      end
    endcase
  end

  // sync and state registers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      s1_q         <= 1'b1;
      s2_q         <= 1'b1;
      st_q         <= RX_IDLE;
      cnt_q        <= 10'h000;
      bit_q        <= 3'h0;
      sh_q         <= 8'h00;
      byte_q       <= 8'h00;
      byte_valid_q <= 1'b0;
    end else begin
      s1_q         <= rx_pin;
      s2_q         <= s1_q;
      st_q         <= st_d;
      cnt_q        <= cnt_d;
      bit_q        <= bit_d;
      sh_q         <= sh_d;
      byte_q       <= byte_d;
      byte_valid_q <= byte_valid_d;
    end
  end

endmodule // mpcd_uart_rx
`default_nettype wire

//--- hw/mpcd_decoder.sv
// midi playback command decoder and master note sender
// Operation
// - status bytes have msb set, data clear
// - status low nibble matched against configured channel
// - mode input selects master, slave or off
// - program change byte selects bank and page
// - note-on sets slider index to level
// - slider indices are zero based
// - aftertouch carries slider index then chase code
// - timecode quarter frames assemble a start time
// - master mode sends note-on and note-off messages
`timescale 1ns/1ns
`default_nettype none
`include "mpcd_consts.svh"

module mpcd_decoder
  import mpcd_pkg::*;
(
  input  wire logic           ref_clk,
  input  wire logic           resetn,
  input  wire logic           midi_rx,
  output var  logic           midi_tx_q,
  input  wire mpcd_mode_type  mode,
  input  wire logic [3:0]     channel,
  input  wire logic           note_req,
  input  wire mpcd_note_type  note_in,
  output var  logic           note_ready_q,
  output var  logic           page_valid_q,
  output var  mpcd_page_type  page_q,
  output var  logic           fader_valid_q,
  output var  mpcd_fader_type fader_q,
  output var  logic           chase_valid_q,
  output var  mpcd_chase_type chase_q,
  output var  logic           time_valid_q,
  output var  mpcd_time_type  time_q
);

  typedef enum logic [1:0] {P_IDLE, P_D1, P_D2} mpcd_parse_type;
  typedef enum logic [2:0] {K_NONE, K_PAGE, K_FADER, K_CHASE, K_TC} mpcd_kind_type;
  typedef enum logic       {T_IDLE, T_BIT} mpcd_tx_type;

  logic [7:0]     rx_byte;                  // received byte
  logic           rx_valid;                 // received byte strobe
  mpcd_parse_type pst_q, pst_d;             // parser position
  mpcd_kind_type  kind_q, kind_d;           // message being parsed
  logic [6:0]     d1_q, d1_d;               // first data byte
  logic [3:0]     qf_q [8];                 // quarter frame nibbles
  logic [3:0]     qf_d [8];
  logic           page_valid_d;
  mpcd_page_type  page_d;
  logic           fader_valid_d;
  mpcd_fader_type fader_d;
  logic           chase_valid_d;
  mpcd_chase_type chase_d;
  logic           time_valid_d;
  mpcd_time_type  time_d;

  // byte receiver on the midi input pin
  mpcd_uart_rx u_rx (
    .ref_clk      (ref_clk),
    .resetn       (resetn),
    .rx_pin       (midi_rx),
    .byte_q       (rx_byte),
    .byte_valid_q (rx_valid)
  );

  // message parser
  always_comb begin
    logic [6:0] b;
    b             = rx_byte[6:0];
    pst_d         = pst_q;
    kind_d        = kind_q;
    d1_d          = d1_q;
    qf_d          = qf_q;
    page_valid_d  = 1'b0;
    page_d        = page_q;
    fader_valid_d = 1'b0;
    fader_d       = fader_q;
    chase_valid_d = 1'b0;
    chase_d       = chase_q;
    time_valid_d  = 1'b0;
    time_d        = time_q;
    if (rx_valid) begin
      if (rx_byte[7]) begin
        if (rx_byte[7:4] == `MPCD_ST_SYSTEM) begin
          if (!rx_byte[3]) begin            // realtime bytes leave parse alone
            if (rx_byte == `MPCD_QF_STATUS && mode != MPCD_MODE_OFF) begin
              kind_d = K_TC;
              pst_d  = P_D1;
            end else begin
              kind_d = K_NONE;
              pst_d  = P_IDLE;
            end
          end
        end else if (mode == MPCD_MODE_SLAVE && rx_byte[3:0] == channel) begin
          pst_d = P_D1;
          unique case (rx_byte[7:4])
            `MPCD_ST_PAGE:    kind_d = K_PAGE;
            `MPCD_ST_NOTE_ON: kind_d = K_FADER;
            `MPCD_ST_CHASE:   kind_d = K_CHASE;
            default: begin
              kind_d = K_NONE;
              pst_d  = P_IDLE;
            end
          endcase
        end else begin
          kind_d = K_NONE;
          pst_d  = P_IDLE;
        end
      end else if (mode == MPCD_MODE_SLAVE || (kind_q == K_TC && mode != MPCD_MODE_OFF)) begin
        // data bytes only complete a message while its mode still allows it
        unique case (pst_q)
          P_IDLE: ;                         // stray data ignored
          P_D1: begin
            pst_d = P_IDLE;
            unique case (kind_q)
              K_PAGE: begin
                page_valid_d = 1'b1;
                if (b >= `MPCD_PG_A_FIRST) begin
                  page_d.bank = 4'h0;
                  page_d.page = 2'(b - `MPCD_PG_A_BASE);
                end else if (b >= `MPCD_PG1_FIRST && b <= `MPCD_PG1_LAST) begin
                  page_d.bank = 4'(b - `MPCD_PG1_BASE);
                  page_d.page = 2'h1;
                end else if (b >= `MPCD_PG2_FIRST && b <= `MPCD_PG2_LAST) begin
                  page_d.bank = 4'(b - `MPCD_PG2_BASE);
                  page_d.page = 2'h2;
                end else if (b >= `MPCD_PG3_FIRST && b <= `MPCD_PG3_LAST) begin
                  page_d.bank = 4'(b - `MPCD_PG3_BASE);
                  page_d.page = 2'h3;
                end else begin
                  page_valid_d = 1'b0;      // unmapped value dropped
                end
              end
              K_FADER, K_CHASE: begin
                d1_d  = b;
                pst_d = P_D2;
              end
              K_TC: begin
                qf_d[rx_byte[6:4]] = rx_byte[3:0];
                if (rx_byte[6:4] == `MPCD_QF_LAST) begin
                  time_valid_d  = 1'b1;
                  time_d.frames = {qf_q[1][0], qf_q[0]};
                  time_d.secs   = {qf_q[3][1:0], qf_q[2]};
                  time_d.mins   = {qf_q[5][1:0], qf_q[4]};
                  time_d.hours  = {rx_byte[0], qf_q[6]};
                  time_d.rate   = rx_byte[2:1];
                end
              end
              default: ;
            endcase
          end
          P_D2: begin
            pst_d = P_IDLE;
            if (d1_q <= `MPCD_FADER_MAX) begin
              if (kind_q == K_FADER) begin
                fader_valid_d = 1'b1;
                fader_d.index = d1_q[4:0];
                fader_d.level = b;
              end else if (b <= `MPCD_CHASE_MAX) begin
                chase_valid_d = 1'b1;
                chase_d.index = d1_q[4:0];
                chase_d.code  = b[2:0];
              end
            end
          end
          default: pst_d = P_IDLE;
        endcase
      end
    end
  end

  // parser registers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      pst_q         <= P_IDLE;
      kind_q        <= K_NONE;
      d1_q          <= 7'h00;
      qf_q          <= '{default: 4'h0};
      page_valid_q  <= 1'b0;
      page_q        <= '0;
      fader_valid_q <= 1'b0;
      fader_q       <= '0;
      chase_valid_q <= 1'b0;
      chase_q       <= '0;
      time_valid_q  <= 1'b0;
      time_q        <= '0;
    end else begin
      pst_q         <= pst_d;
      kind_q        <= kind_d;
      d1_q          <= d1_d;
      qf_q          <= qf_d;
      page_valid_q  <= page_valid_d;
      page_q        <= page_d;
      fader_valid_q <= fader_valid_d;
      fader_q       <= fader_d;
      chase_valid_q <= chase_valid_d;
      chase_q       <= chase_d;
      time_valid_q  <= time_valid_d;
      time_q        <= time_d;
    end
  end

  mpcd_tx_type tst_q, tst_d;                // sender state
  logic [9:0]  tsh_q, tsh_d;                // frame shift, lsb out first
  logic [3:0]  tbit_q, tbit_d;              // bit index in frame
  logic [9:0]  tcnt_q, tcnt_d;              // bit timer
  logic [1:0]  tbyte_q, tbyte_d;            // byte index in message
  logic [6:0]  tkey_q, tkey_d;              // pending key byte
  logic [6:0]  tvel_q, tvel_d;              // pending velocity byte
  logic        midi_tx_d;
  logic        note_ready_d;

  // master sender: three byte note messages
  always_comb begin
    tst_d   = tst_q;
    tsh_d   = tsh_q;
    tbit_d  = tbit_q;
    tcnt_d  = tcnt_q;
    tbyte_d = tbyte_q;
    tkey_d  = tkey_q;
    tvel_d  = tvel_q;
    unique case (tst_q)
      T_IDLE: begin
        if (note_req && note_ready_q && mode == MPCD_MODE_MASTER) begin
          tst_d   = T_BIT;
          tsh_d   = {1'b1, (note_in.on ? `MPCD_ST_NOTE_ON : `MPCD_ST_NOTE_OFF), channel, 1'b0};
          tbit_d  = 4'h0;
          tcnt_d  = 10'h000;
          tbyte_d = 2'h0;
          tkey_d  = note_in.key;
          tvel_d  = note_in.vel;
        end
      end
      T_BIT: begin
        tcnt_d = tcnt_q + 10'h001;
        if (tcnt_q == 10'(`MPCD_BIT_CYC - 1)) begin
          tcnt_d = 10'h000;
          tsh_d  = {1'b1, tsh_q[9:1]};
          tbit_d = tbit_q + 4'h1;
          if (tbit_q == `MPCD_FRAME_BITS) begin
            tbit_d  = 4'h0;
            tbyte_d = tbyte_q + 2'h1;
            unique case (tbyte_q)
              2'h0:    tsh_d = {2'b10, tkey_q, 1'b0};
              2'h1:    tsh_d = {2'b10, tvel_q, 1'b0};
              default: tst_d = T_IDLE;
            endcase
          end
        end
      end
    endcase
    midi_tx_d    = (tst_d == T_BIT) ? tsh_d[0] : 1'b1;
    note_ready_d = (tst_d == T_IDLE) && (mode == MPCD_MODE_MASTER);
  end

  // sender registers
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      tst_q        <= T_IDLE;
      tsh_q        <= 10'h3FF;
      tbit_q       <= 4'h0;
      tcnt_q       <= 10'h000;
      tbyte_q      <= 2'h0;
      tkey_q       <= 7'h00;
      tvel_q       <= 7'h00;
      midi_tx_q    <= 1'b1;
      note_ready_q <= 1'b0;
    end else begin
      tst_q        <= tst_d;
      tsh_q        <= tsh_d;
      tbit_q       <= tbit_d;
      tcnt_q       <= tcnt_d;
      tbyte_q      <= tbyte_d;
      tkey_q       <= tkey_d;
      tvel_q       <= tvel_d;
      midi_tx_q    <= midi_tx_d;
      note_ready_q <= note_ready_d;
    end
  end

endmodule // mpcd_decoder
`default_nettype wire

//--- tb/mpcd_decoder_props.sv
// assertion checker on the midi playback decoder ports
`timescale 1ns/1ns
`default_nettype none
module mpcd_decoder_props
  import mpcd_pkg::*;
(
  input wire logic           ref_clk,
  input wire logic           resetn,
  input wire logic           midi_rx,
  input wire logic           midi_tx_q,
  input wire mpcd_mode_type  mode,
  input wire logic [3:0]     channel,
  input wire logic           note_req,
  input wire mpcd_note_type  note_in,
  input wire logic           note_ready_q,
  input wire logic           page_valid_q,
  input wire mpcd_page_type  page_q,
  input wire logic           fader_valid_q,
  input wire mpcd_fader_type fader_q,
  input wire logic           chase_valid_q,
  input wire mpcd_chase_type chase_q,
  input wire logic           time_valid_q,
  input wire mpcd_time_type  time_q
);
  logic        prev_q;   // serial out level last edge
  logic        prev_d;
  logic [15:0] run_q;    // edges spent at that level
  logic [15:0] run_d;

  // length of the current serial output level
  always_comb begin
    prev_d = midi_tx_q;
    run_d  = (midi_tx_q == prev_q) ? run_q + 16'h1 : 16'h1;
  end

  // register the run counter
  always_ff @(posedge ref_clk) begin
    if (!resetn) begin
      prev_q <= 1'b1;
      run_q  <= 16'h0;
    end else begin
      prev_q <= prev_d;
      run_q  <= run_d;
    end
  end

  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);

  a_reset_idle: assert property (disable iff (1'b0) !resetn |=> midi_tx_q && !note_ready_q
    && !page_valid_q && !fader_valid_q && !chase_valid_q && !time_valid_q) else $error("outputs busy after reset");
  a_ready_master: assert property (mode != MPCD_MODE_MASTER |=> !note_ready_q)
    else $error("note ready outside master mode");
  a_take_start: assert property (note_req && note_ready_q && mode == MPCD_MODE_MASTER
    |=> !note_ready_q && !midi_tx_q) else $error("note request did not start a frame");
  a_low_bits: assert property (midi_tx_q && !prev_q |-> (run_q % 16'h280) == 16'h0)
    else $error("low run not whole bit times");
  a_slave_only: assert property (mode != MPCD_MODE_SLAVE && $past(mode) != MPCD_MODE_SLAVE
    |=> !(page_valid_q || fader_valid_q || chase_valid_q)) else $error("command decoded outside slave");
  a_page_range: assert property (page_valid_q |-> page_q.bank <= 4'h9 && page_q.page != 2'h0)
    else $error("page out of table");
  a_page_hold: assert property ($changed(page_q) && $past(resetn) |-> page_valid_q)
    else $error("page changed without pulse");
  a_fader_index: assert property (fader_valid_q |-> fader_q.index <= 5'h13)
    else $error("fader index above last");
  a_fader_hold: assert property ($changed(fader_q) && $past(resetn) |-> fader_valid_q)
    else $error("fader changed without pulse");
  a_chase_code: assert property (chase_valid_q |-> chase_q.code <= 3'h4)
    else $error("chase code above last");
endmodule // mpcd_decoder_props
`default_nettype wire

//--- tb/mpcd_midi_partner.sv
// midi instrument model: sends frames in, reads frames out
`timescale 1ns/1ns
`default_nettype none
module mpcd_midi_partner (
  input  wire logic       ref_clk,
  input  wire logic       midi_tx_q,
  output var  logic       midi_rx,
  output var  logic [7:0] got_byte,
  output var  logic       got_strobe
);
  logic [9:0] rx_sh;  // frame being received

  // idle line is high
  initial begin
    midi_rx    = 1'b1;
    got_byte   = 8'h00;
    got_strobe = 1'b0;
  end

  // one frame, start low, lsb first, stop high, 640 clocks a bit
  task send_byte(input logic [7:0] b);
    logic [9:0] fr;
    int         i;
    fr = {1'b1, b, 1'b0};
    for (i = 0; i < 10; i++) begin
      @(negedge ref_clk);
      midi_rx = fr[i];
      repeat (639) @(negedge ref_clk);
    end
  endtask

  // receiver samples each bit in its middle
  always begin
    @(negedge midi_tx_q);
    repeat (320) @(posedge ref_clk);
    for (int i = 0; i < 10; i++) begin
      rx_sh[i] = midi_tx_q;
      if (i < 9) repeat (640) @(posedge ref_clk);
    end
    // framing bad: byte dropped
    if (rx_sh[0] == 1'b0 && rx_sh[9] == 1'b1) begin
      got_byte   = rx_sh[8:1];
      got_strobe = 1'b1;
      @(posedge ref_clk);
      got_strobe = 1'b0;
    end
  end
endmodule // mpcd_midi_partner
`default_nettype wire

//--- tb/mpcd_decoder_tb_top.sv
// self-checking bench for the midi playback decoder
`timescale 1ns/1ns
`default_nettype none
module mpcd_decoder_tb_top
  import mpcd_pkg::*;
;
  logic           ref_clk;      // 20 MHz clock
  logic           resetn;       // sync reset
  logic           midi_rx;      // serial in from partner
  logic           midi_tx_q;    // serial out
  mpcd_mode_type  mode;         // operating mode
  logic [3:0]     channel;      // configured channel
  logic           note_req;     // send request
  mpcd_note_type  note_in;      // note to send
  logic           note_ready_q, page_valid_q, fader_valid_q, chase_valid_q, time_valid_q;
  mpcd_page_type  page_q;
  mpcd_fader_type fader_q;
  mpcd_chase_type chase_q;
  mpcd_time_type  time_q;
  logic [7:0]     got_byte;     // byte read off midi_tx_q
  logic           got_strobe;
  logic [17:0]    exp_q[$];     // expected results: kind, value
  mpcd_time_type  exp_t_q[$];   // expected timecode results
  int             num_errors = 0;
  int             n_checks = 0;
  logic [3:0]     ch;
  logic [6:0]     lvl;
  mpcd_note_type  nt;

  // clock
  initial ref_clk = 1'b0;
  always #25 ref_clk = ~ref_clk;

  mpcd_decoder uut (.ref_clk(ref_clk), .resetn(resetn), .midi_rx(midi_rx), .midi_tx_q(midi_tx_q),
    .mode(mode), .channel(channel), .note_req(note_req), .note_in(note_in), .note_ready_q(note_ready_q),
    .page_valid_q(page_valid_q), .page_q(page_q), .fader_valid_q(fader_valid_q), .fader_q(fader_q),
    .chase_valid_q(chase_valid_q), .chase_q(chase_q), .time_valid_q(time_valid_q), .time_q(time_q));

  mpcd_midi_partner partner (.ref_clk(ref_clk), .midi_tx_q(midi_tx_q), .midi_rx(midi_rx),
    .got_byte(got_byte), .got_strobe(got_strobe));

  // compare one result
  task check_val(input string what, input logic [17:0] exp, input logic [17:0] got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  // compare one timecode result
  task check_time(input mpcd_time_type exp, input mpcd_time_type got);
    n_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH time expected %h seen %h", exp, got);
    end
  endtask

  // oldest note against a seen result
  task take(input string what, input logic [17:0] got);
    if (exp_q.size() == 0) begin
      num_errors++;
      $display("MISMATCH %s expected none seen %h", what, got);
    end else check_val(what, exp_q.pop_front(), got);
  endtask

  // watcher: every result pulse takes a note
  always @(posedge ref_clk) begin
    #1;
    if (page_valid_q === 1'b1) take("page", {2'h0, 10'h0, page_q});
    if (fader_valid_q === 1'b1) take("fader", {2'h1, 4'h0, fader_q});
    if (chase_valid_q === 1'b1) take("chase", {2'h2, 8'h0, chase_q});
    if (got_strobe === 1'b1) take("tx byte", {2'h3, 8'h0, got_byte});
    if (time_valid_q === 1'b1) begin
      if (exp_t_q.size() == 0) begin
        num_errors++;
        $display("MISMATCH time expected none seen %h", time_q);
      end else check_time(exp_t_q.pop_front(), time_q);
    end
  end

  // message of two or three bytes
  task send3(input logic [7:0] a, input logic [7:0] b, input logic [7:0] c, input int n);
    partner.send_byte(a);
    partner.send_byte(b);
    if (n == 3) partner.send_byte(c);
  endtask

  // note request pulsed for one clock after waiting up to 20 clocks for ready
  task send_note(input mpcd_note_type n);
    int i;
    for (i = 0; i < 20 && note_ready_q !== 1'b1; i++) @(negedge ref_clk);
    note_in  = n;
    note_req = 1'b1;
    @(negedge ref_clk);
    note_req = 1'b0;
  endtask

  // verdict and end of run
  task give_verdict;
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0) $display("Regression OK");
    else $display("Regression broken");
    $finish;
  endtask

  // watchdog
  initial begin
    #8000000;
    num_errors++;
    $display("MISMATCH watchdog expected done seen timeout");
    give_verdict;
  end

  // main sequence
  initial begin
    void'($urandom(32'h5BBB1761));
    ch       = 4'($urandom());
    lvl      = 7'($urandom());
    nt       = 15'($urandom());
    resetn   = 1'b0;
    mode     = MPCD_MODE_SLAVE;
    channel  = ch;
    note_req = 1'b0;
    note_in  = 15'h0;
    repeat (8) @(negedge ref_clk);
    resetn = 1'b1;
    repeat (2) @(negedge ref_clk);
    exp_q.push_back({2'h1, 4'h0, 5'h13, lvl});
    send3({4'h9, ch}, 8'h13, {1'b0, lvl}, 3);
    exp_q.push_back({2'h0, 10'h0, 4'h5, 2'h3});
    send3({4'hC, ch}, 8'h19, 8'h00, 2);
    exp_q.push_back({2'h2, 8'h0, 5'h03, 3'h4});
    send3({4'hA, ch}, 8'h03, 8'h04, 3);
    // other channel, then a data byte with no status: both ignored
    send3({4'hC, ch ^ 4'h1}, 8'h04, 8'h7D, 3);
    // master: note goes out while a received note-on is ignored
    mode = MPCD_MODE_MASTER;
    exp_q.push_back({2'h3, 8'h0, nt.on ? 4'h9 : 4'h8, ch});
    exp_q.push_back({2'h3, 8'h0, 1'b0, nt.key});
    exp_q.push_back({2'h3, 8'h0, 1'b0, nt.vel});
    // piece 7 alone: hours msb and rate, other pieces still zero from reset
    exp_t_q.push_back({2'h1, 5'h10, 6'h00, 6'h00, 5'h00});
    fork
      send_note(nt);
      begin
        send3({4'h9, ch}, 8'h05, 8'h10, 3);
        send3(8'hF1, 8'h7B, 8'h00, 2);
      end
    join
    // mode off: sender must no longer offer to take a note
    mode = MPCD_MODE_OFF;
    repeat (20) @(negedge ref_clk);
    check_val("ready off", 18'h0, {17'h0, note_ready_q});
    check_val("pending", 18'h0, 18'(exp_q.size()));
    check_val("time pending", 18'h0, 18'(exp_t_q.size()));
    give_verdict;
  end
endmodule // mpcd_decoder_tb_top
`default_nettype wire

bind mpcd_decoder mpcd_decoder_props u_props (.ref_clk(ref_clk), .resetn(resetn), .midi_rx(midi_rx),
  .midi_tx_q(midi_tx_q), .mode(mode), .channel(channel), .note_req(note_req), .note_in(note_in),
  .note_ready_q(note_ready_q), .page_valid_q(page_valid_q), .page_q(page_q), .fader_valid_q(fader_valid_q),
  .fader_q(fader_q), .chase_valid_q(chase_valid_q), .chase_q(chase_q), .time_valid_q(time_valid_q),
  .time_q(time_q));
